// file: ersi_pkg.sv
package ersi_pkg;
   // synchronised input vector layout
   // nine single pins plus the two-bit relay C jumper
   localparam int IN_W = 11;
   localparam int POS_CLK_ONE = 0;
   localparam int POS_CLK_TWO = 1;
   localparam int POS_SWITCH = 2;
   localparam int POS_PPS = 3;
   localparam int POS_TEN_MHZ = 4;
   localparam int POS_NOTIFY = 5;
   localparam int POS_INIT_DONE = 6;
   localparam int POS_SEL_A = 7;
   localparam int POS_SEL_B = 8;
   localparam int POS_SEL_C = 9;
   localparam int SEL_C_W = 2;
   localparam int RAW_RESET = 0;

   // relay C jumper codes
   localparam logic [1:0] SEL_C_SWITCH = 2'h0;
   localparam logic [1:0] SEL_C_TEN_MHZ = 2'h1;
   localparam logic [1:0] SEL_C_NOTIFY = 2'h2;

   // lamp colours as {red, green, blue}
   localparam logic [2:0] LAMP_OFF = 3'h0;
   localparam logic [2:0] LAMP_BLUE = 3'h1;
   localparam logic [2:0] LAMP_GREEN = 3'h2;
   localparam logic [2:0] LAMP_RED = 3'h4;
   localparam logic [2:0] LAMP_YELLOW = 3'h6;

   // boot step timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam longint BOOT_STEP_PS = 64'h0000_00E8_D4A5_1000;
   localparam int BOOT_STEP_CYCLES = int'(BOOT_STEP_PS / CLK_PERIOD_PS);
   localparam int CNT_W = 28;
   localparam logic [CNT_W-1:0] CNT_RESET = 28'h000_0000;
   localparam logic [1:0] STEP_RESET = 2'h0;
   localparam logic [1:0] STEP_LAST = 2'h3;

   typedef enum logic [1:0] {PH_INIT, PH_BOOT, PH_NORMAL} ersi_phase_t;
endpackage

// file: ersi_sync_if.sv
`timescale 1ns/1ps
interface ersi_sync_if;
   logic [ersi_pkg::IN_W-1:0] raw;
   logic [ersi_pkg::IN_W-1:0] synced;
   modport bank (input raw, output synced);
   modport user (output raw, input synced);
endinterface

// file: ersi_sync_bank.sv
`timescale 1ns/1ps
module ersi_sync_bank (
   input wire ref_clk,
   input wire sys_rst,
   input wire clkEn,
   ersi_sync_if.bank port
);
   logic [ersi_pkg::IN_W-1:0] stageOne_reg;
   logic [ersi_pkg::IN_W-1:0] stageTwo_reg;
   logic [ersi_pkg::IN_W-1:0] stageOne_next;
   logic [ersi_pkg::IN_W-1:0] stageTwo_next;

   // two flops per pin; first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < ersi_pkg::IN_W; i++) begin : g_bit
         always_comb begin
            stageOne_next[i] = clkEn ? port.raw[i] : stageOne_reg[i];
            stageTwo_next[i] = clkEn ? stageOne_reg[i] : stageTwo_reg[i];
         end
         always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
               stageOne_reg[i] <= 1'b0;
               stageTwo_reg[i] <= 1'b0;
            end else begin
               stageOne_reg[i] <= stageOne_next[i];
               stageTwo_reg[i] <= stageTwo_next[i];
            end
         end
      end
   endgenerate

   assign port.synced = stageTwo_reg;
endmodule

// file: ersi_error_relay.sv
// Contract
// - relay open while source synchronous
// - relay closed on source error
// - default jumpers: clock1-A, clock2-B, switch-C
// - jumpers pick each relay's source
// - boot: lamps red, yellow, green, off, 1s each
// - normal: lamp A green, red on clock1 error
// - normal: lamp B green, red on clock2 error
// - normal: lamp C green, red on notification error
`timescale 1ns/1ps
module ersi_error_relay #(
   parameter int BOOT_STEP_CYCLES = ersi_pkg::BOOT_STEP_CYCLES
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire clkEn,
   input wire clockOneSync,
   input wire clockTwoSync,
   input wire switchUnitOk,
   input wire ppsOk,
   input wire tenMhzOk,
   input wire notifyErr,
   input wire initDone,
   input wire relaySelA,
   input wire relaySelB,
   input wire [1:0] relaySelC,
   output logic relayAFault,
   output logic relayBFault,
   output logic relayCFault,
   output logic [2:0] statusLamp,
   output logic [2:0] lampA,
   output logic [2:0] lampB,
   output logic [2:0] lampC
);
   localparam logic [ersi_pkg::CNT_W-1:0] STEP_END = ersi_pkg::CNT_W'(BOOT_STEP_CYCLES - 1);

   ersi_sync_if syncIf ();

   // pins enter through the synchroniser bank
   assign syncIf.raw = {relaySelC, relaySelB, relaySelA, initDone, notifyErr,
                        tenMhzOk, ppsOk, switchUnitOk, clockTwoSync, clockOneSync};

   ersi_sync_bank u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .port(syncIf.bank)
   );

   logic clkOneOk;
   logic clkTwoOk;
   logic switchOk;
   logic ppsGood;
   logic tenGood;
   logic notifyBad;
   logic initSeen;
   logic selA;
   logic selB;
   logic [1:0] selC;

   assign clkOneOk = syncIf.synced[ersi_pkg::POS_CLK_ONE];
   assign clkTwoOk = syncIf.synced[ersi_pkg::POS_CLK_TWO];
   assign switchOk = syncIf.synced[ersi_pkg::POS_SWITCH];
   assign ppsGood = syncIf.synced[ersi_pkg::POS_PPS];
   assign tenGood = syncIf.synced[ersi_pkg::POS_TEN_MHZ];
   assign notifyBad = syncIf.synced[ersi_pkg::POS_NOTIFY];
   assign initSeen = syncIf.synced[ersi_pkg::POS_INIT_DONE];
   assign selA = syncIf.synced[ersi_pkg::POS_SEL_A];
   assign selB = syncIf.synced[ersi_pkg::POS_SEL_B];
   assign selC = syncIf.synced[ersi_pkg::POS_SEL_C +: ersi_pkg::SEL_C_W];

   ersi_pkg::ersi_phase_t phase_reg, phase_next;
   logic [ersi_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic [1:0] step_reg, step_next;
   logic relayA_reg, relayA_next;
   logic relayB_reg, relayB_next;
   logic relayC_reg, relayC_next;
   logic [2:0] status_reg, status_next;
   logic [2:0] lampA_reg, lampA_next;
   logic [2:0] lampB_reg, lampB_next;
   logic [2:0] lampC_reg, lampC_next;
   logic [2:0] bootColour;
   logic stepDone;

   assign stepDone = (cnt_reg == STEP_END);

   // phase sequencer, relay source muxes and lamp colours
   always_comb begin
      phase_next = phase_reg;
      cnt_next = cnt_reg;
      step_next = step_reg;
      unique case (step_reg)
         2'h0: bootColour = ersi_pkg::LAMP_RED;
         2'h1: bootColour = ersi_pkg::LAMP_YELLOW;
         2'h2: bootColour = ersi_pkg::LAMP_GREEN;
         2'h3: bootColour = ersi_pkg::LAMP_OFF;
      endcase
      unique case (phase_reg)
         ersi_pkg::PH_INIT: begin
            if (initSeen) begin
               phase_next = ersi_pkg::PH_BOOT;
               cnt_next = ersi_pkg::CNT_RESET;
               step_next = ersi_pkg::STEP_RESET;
            end
         end
         ersi_pkg::PH_BOOT: begin
            // each colour held for one second
            if (stepDone) begin
               cnt_next = ersi_pkg::CNT_RESET;
               step_next = step_reg + 2'h1;
               if (step_reg == ersi_pkg::STEP_LAST) begin
                  phase_next = ersi_pkg::PH_NORMAL;
               end
            end else begin
               cnt_next = cnt_reg + ersi_pkg::CNT_W'(1);
            end
         end
         ersi_pkg::PH_NORMAL: begin
            cnt_next = cnt_reg;
         end
         default: begin
            phase_next = ersi_pkg::PH_INIT;
         end
      endcase

      // relays track their source in every phase; fault high means closed contact
      relayA_next = selA ? notifyBad : !clkOneOk;
      relayB_next = selB ? !ppsGood : !clkTwoOk;
      unique case (selC)
         ersi_pkg::SEL_C_TEN_MHZ: relayC_next = !tenGood;
         ersi_pkg::SEL_C_NOTIFY: relayC_next = notifyBad;
         default: relayC_next = !switchOk; // unused code falls back to default wiring
      endcase

      unique case (phase_reg)
         ersi_pkg::PH_BOOT: begin
            status_next = ersi_pkg::LAMP_BLUE;
            lampA_next = bootColour;
            lampB_next = bootColour;
            lampC_next = bootColour;
         end
         ersi_pkg::PH_NORMAL: begin
            status_next = ersi_pkg::LAMP_GREEN;
            lampA_next = clkOneOk ? ersi_pkg::LAMP_GREEN : ersi_pkg::LAMP_RED;
            lampB_next = clkTwoOk ? ersi_pkg::LAMP_GREEN : ersi_pkg::LAMP_RED;
            lampC_next = notifyBad ? ersi_pkg::LAMP_RED : ersi_pkg::LAMP_GREEN;
         end
         default: begin
            status_next = ersi_pkg::LAMP_BLUE;
            lampA_next = ersi_pkg::LAMP_OFF;
            lampB_next = ersi_pkg::LAMP_OFF;
            lampC_next = ersi_pkg::LAMP_OFF;
         end
      endcase
   end

   // registers; clock enable freezes everything
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_reg <= ersi_pkg::PH_INIT;
         cnt_reg <= ersi_pkg::CNT_RESET;
         step_reg <= ersi_pkg::STEP_RESET;
         relayA_reg <= 1'b1; // safe side: fault until a source is seen
         relayB_reg <= 1'b1;
         relayC_reg <= 1'b1;
         status_reg <= ersi_pkg::LAMP_BLUE;
         lampA_reg <= ersi_pkg::LAMP_OFF;
         lampB_reg <= ersi_pkg::LAMP_OFF;
         lampC_reg <= ersi_pkg::LAMP_OFF;
      end else if (clkEn) begin
         phase_reg <= phase_next;
         cnt_reg <= cnt_next;
         step_reg <= step_next;
         relayA_reg <= relayA_next;
         relayB_reg <= relayB_next;
         relayC_reg <= relayC_next;
         status_reg <= status_next;
         lampA_reg <= lampA_next;
         lampB_reg <= lampB_next;
         lampC_reg <= lampC_next;
      end
   end

   assign relayAFault = relayA_reg;
   assign relayBFault = relayB_reg;
   assign relayCFault = relayC_reg;
   assign statusLamp = status_reg;
   assign lampA = lampA_reg;
   assign lampB = lampB_reg;
   assign lampC = lampC_reg;

   // checks hold while the clock enable stays high
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst || !clkEn);

   property p_relay_open;
      clkEn && !selA && clkOneOk |=> !relayAFault;
   endproperty
   a_relay_open: assert property (p_relay_open) else $error("relay A not open while synchronous");

   property p_relay_closed;
      clkEn && !selB && !clkTwoOk |=> relayBFault;
   endproperty
   a_relay_closed: assert property (p_relay_closed) else $error("relay B not closed on error");

   property p_default_c;
      clkEn && selC == ersi_pkg::SEL_C_SWITCH |=> relayCFault == !$past(switchOk);
   endproperty
   a_default_c: assert property (p_default_c) else $error("relay C not on switch unit");

   property p_sel_alt;
      clkEn && selA && selB && selC == ersi_pkg::SEL_C_NOTIFY
         |=> relayAFault == $past(notifyBad) && relayBFault == !$past(ppsGood) && relayCFault == $past(notifyBad);
   endproperty
   a_sel_alt: assert property (p_sel_alt) else $error("jumper source not followed");

   property p_init_lamps;
      clkEn && phase_reg == ersi_pkg::PH_INIT
         |=> statusLamp == ersi_pkg::LAMP_BLUE && lampA == ersi_pkg::LAMP_OFF && lampB == ersi_pkg::LAMP_OFF
         && lampC == ersi_pkg::LAMP_OFF;
   endproperty
   a_init_lamps: assert property (p_init_lamps) else $error("init lamps wrong");

   sequence s_step_end;
      phase_reg == ersi_pkg::PH_BOOT && step_reg == ersi_pkg::STEP_LAST && stepDone;
   endsequence
   sequence s_normal_next;
      ##1 phase_reg == ersi_pkg::PH_NORMAL ##1 statusLamp == ersi_pkg::LAMP_GREEN;
   endsequence
   property p_boot_end;
      // clock enable already gates this through the default disable
      s_step_end |-> s_normal_next;
   endproperty
   a_boot_end: assert property (p_boot_end) else $error("boot did not end after last step");

   property p_boot_step;
      clkEn && phase_reg == ersi_pkg::PH_BOOT && step_reg == 2'h0 && !stepDone
         |=> step_reg == 2'h0 && lampB == ersi_pkg::LAMP_RED;
   endproperty
   a_boot_step: assert property (p_boot_step) else $error("boot step left early");

   property p_lamp_a;
      clkEn && phase_reg == ersi_pkg::PH_NORMAL |=> lampA == ($past(clkOneOk) ? ersi_pkg::LAMP_GREEN : ersi_pkg::LAMP_RED);
   endproperty
   a_lamp_a: assert property (p_lamp_a) else $error("lamp A wrong");

   property p_lamp_b;
      clkEn && phase_reg == ersi_pkg::PH_NORMAL && !clkTwoOk |=> lampB == ersi_pkg::LAMP_RED;
   endproperty
   a_lamp_b: assert property (p_lamp_b) else $error("lamp B not red on error");

   property p_lamp_c;
      clkEn && phase_reg == ersi_pkg::PH_NORMAL && !notifyBad |=> lampC == ersi_pkg::LAMP_GREEN;
   endproperty
   a_lamp_c: assert property (p_lamp_c) else $error("lamp C not green");
endmodule

// file: ersi_source_model.sv
`timescale 1ns/1ps
module ersi_source_model (
   input wire ref_clk,
   input wire slow,
   input wire [5:0] errCmd,
   output logic clockOneSync,
   output logic clockTwoSync,
   output logic switchUnitOk,
   output logic ppsOk,
   output logic tenMhzOk,
   output logic notifyErr
);
   logic [5:0] okNear = 6'h3f;
   logic [5:0] okFar = 6'h3f;
   logic [5:0] okNow;
   // sources settle after one cycle, or two when lagging
   always @(posedge ref_clk) begin
      okNear <= ~errCmd;
      okFar <= okNear;
   end
   // slow mode mimics a card that reports its state late
   assign okNow = slow ? okFar : okNear;
   assign clockOneSync = okNow[0];
   assign clockTwoSync = okNow[1];
   assign switchUnitOk = okNow[2];
   assign ppsOk = okNow[3];
   assign tenMhzOk = okNow[4];
   assign notifyErr = ~okNow[5];
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int STEP = 8;
   localparam int LIMIT = 3000;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clkEn = 1'b1;
   logic initDone = 1'b0;
   logic relaySelA = 1'b0;
   logic relaySelB = 1'b0;
   logic [1:0] relaySelC = 2'h0;
   logic [5:0] errCmd = 6'h00;
   logic slow = 1'b0;
   wire clockOneSync, clockTwoSync, switchUnitOk, ppsOk, tenMhzOk, notifyErr;
   wire relayAFault, relayBFault, relayCFault;
   wire [2:0] statusLamp, lampA, lampB, lampC;
   int errorCnt = 0;
   int nTests = 0;
   int cycleCnt = 0;

   ersi_source_model u_ersi_source_model (.ref_clk(ref_clk), .slow(slow), .errCmd(errCmd),
      .clockOneSync(clockOneSync), .clockTwoSync(clockTwoSync), .switchUnitOk(switchUnitOk),
      .ppsOk(ppsOk), .tenMhzOk(tenMhzOk), .notifyErr(notifyErr));
   ersi_error_relay #(.BOOT_STEP_CYCLES(STEP)) u_ersi_error_relay (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .clkEn(clkEn), .clockOneSync(clockOneSync), .clockTwoSync(clockTwoSync),
      .switchUnitOk(switchUnitOk), .ppsOk(ppsOk), .tenMhzOk(tenMhzOk), .notifyErr(notifyErr),
      .initDone(initDone), .relaySelA(relaySelA), .relaySelB(relaySelB), .relaySelC(relaySelC),
      .relayAFault(relayAFault), .relayBFault(relayBFault), .relayCFault(relayCFault),
      .statusLamp(statusLamp), .lampA(lampA), .lampB(lampB), .lampC(lampC));

   // 200 MHz clock
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk_bit(input string what, input logic exp, input logic got);
      nTests++;
      if (got !== exp) begin
         errorCnt++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk_lamp(input string what, input logic [2:0] exp, input logic [2:0] got);
      nTests++;
      if (got !== exp) begin
         errorCnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finishTest;
      $display("comparisons %0d mismatches %0d", nTests, errorCnt);
      if (errorCnt == 0 && nTests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // before init completes: blue status, dark relay lamps
   task automatic scen_init;
      repeat (6) @(negedge ref_clk);
      chk_lamp("statusLamp", ersi_pkg::LAMP_BLUE, statusLamp);
      chk_lamp("lampA", ersi_pkg::LAMP_OFF, lampA);
      chk_lamp("lampB", ersi_pkg::LAMP_OFF, lampB);
      chk_lamp("lampC", ersi_pkg::LAMP_OFF, lampC);
      $display("test init finished");
   endtask

   // boot walk: each colour held exactly one step, then normal
   task automatic scen_boot;
      int waitCnt;
      logic [2:0] colours [4];
      colours = '{ersi_pkg::LAMP_RED, ersi_pkg::LAMP_YELLOW, ersi_pkg::LAMP_GREEN, ersi_pkg::LAMP_OFF};
      initDone = 1'b1;
      waitCnt = 0;
      while (lampA !== ersi_pkg::LAMP_RED && waitCnt < 20) begin
         @(negedge ref_clk);
         waitCnt++;
      end
      chk_bit("bootStartInTime", 1'b1, waitCnt <= 5);
      for (int i = 0; i < 4; i++) begin
         chk_lamp("statusLamp", ersi_pkg::LAMP_BLUE, statusLamp);
         chk_lamp("lampA", colours[i], lampA);
         chk_lamp("lampB", colours[i], lampB);
         chk_lamp("lampC", colours[i], lampC);
         repeat (STEP) @(negedge ref_clk);
      end
      repeat (3) @(negedge ref_clk);
      chk_lamp("statusLamp", ersi_pkg::LAMP_GREEN, statusLamp);
      $display("test boot finished");
   endtask

   // every jumper setting against every single fault, fast and slow sources
   task automatic scen_relays;
      logic [3:0] sel;
      logic expC;
      for (int c = 0; c < 7; c++) begin
         for (int s = 0; s < 16; s++) begin
            sel = 4'(s);
            errCmd = (c < 6) ? (6'h01 << c) : 6'h00;
            relaySelA = sel[0];
            relaySelB = sel[1];
            relaySelC = sel[3:2];
            slow = sel[0] ^ c[0];
            repeat (7) @(negedge ref_clk);
            expC = (sel[3:2] == 2'h1) ? errCmd[4] : (sel[3:2] == 2'h2) ? errCmd[5] : errCmd[2];
            chk_bit("relayAFault", sel[0] ? errCmd[5] : errCmd[0], relayAFault);
            chk_bit("relayBFault", sel[1] ? errCmd[3] : errCmd[1], relayBFault);
            chk_bit("relayCFault", expC, relayCFault);
            chk_lamp("lampA", errCmd[0] ? ersi_pkg::LAMP_RED : ersi_pkg::LAMP_GREEN, lampA);
            chk_lamp("lampB", errCmd[1] ? ersi_pkg::LAMP_RED : ersi_pkg::LAMP_GREEN, lampB);
            chk_lamp("lampC", errCmd[5] ? ersi_pkg::LAMP_RED : ersi_pkg::LAMP_GREEN, lampC);
         end
      end
      $display("test relays finished");
   endtask

   // clock enable low must freeze relays and lamps while a source fails
   task automatic scen_freeze;
      relaySelA = 1'b0;
      relaySelB = 1'b0;
      relaySelC = 2'h0;
      errCmd = 6'h00;
      slow = 1'b0;
      repeat (7) @(negedge ref_clk);
      clkEn = 1'b0;
      errCmd = 6'h01;
      repeat (7) @(negedge ref_clk);
      chk_bit("relayAFault", 1'b0, relayAFault);
      chk_lamp("lampA", ersi_pkg::LAMP_GREEN, lampA);
      clkEn = 1'b1;
      repeat (7) @(negedge ref_clk);
      chk_bit("relayAFault", 1'b1, relayAFault);
      chk_lamp("lampA", ersi_pkg::LAMP_RED, lampA);
      $display("test freeze finished");
   endtask

   // hang guard: well above the roughly 860 cycles the tests need
   always @(posedge ref_clk) begin
      cycleCnt++;
      if (cycleCnt == LIMIT) begin
         errorCnt++;
         finishTest();
      end
   end

   initial begin
      repeat (5) @(negedge ref_clk);
      sys_rst = 1'b0;
      scen_init();
      scen_boot();
      scen_relays();
      scen_freeze();
      finishTest();
   end
endmodule
